// [logic/csw_cyclic_sleep.sv]
module csw_cyclic_sleep #(
  parameter int unsigned MS_CYCLES = csw_pkg::MS_CYCLES
) (
  // clock and reset
  input  wire logic                       clk,
  input  wire logic                       reset,
  // register port
  input  wire logic [csw_pkg::ADDR_W-1:0] addr,
  input  wire logic [csw_pkg::DATA_W-1:0] wdata,
  input  wire logic                       wr,
  input  wire logic                       rd,
  output logic      [csw_pkg::DATA_W-1:0] rdata,
  // host pin
  input  wire logic                       sleep_request_pin,
  // data activity
  input  wire logic                       rf_data_rx,
  input  wire logic                       serial_rx,
  // indirect message holding
  input  wire logic                       msg_store,
  input  wire logic                       msg_taken,
  output logic                            msg_discard,
  // status outputs
  output logic                            awake,
  output logic                            awake_indicator,
  output logic                            host_tx_allow
);

  csw_pkg::csw_regs_type r_r;
  csw_pkg::csw_regs_type r_nxt;

  logic ms_tick;
  logic tick_10ms;

  localparam logic [csw_pkg::CHECK_W-1:0] CHECK_LAST =
    csw_pkg::CHECK_W'(csw_pkg::CHECK_TIME_MS - 1);

  csw_prescale #(
    .DIV (MS_CYCLES)
  ) u_ms_div (
    .clk   (clk),
    .reset (reset),
    .en    (1'b1),
    .tick  (ms_tick)
  );

  csw_prescale #(
    .DIV (csw_pkg::SLEEP_UNIT_MS)
  ) u_10ms_div (
    .clk   (clk),
    .reset (reset),
    .en    (ms_tick),
    .tick  (tick_10ms)
  );

  logic                       pin_s;
  logic                       pin_fall;
  logic                       activity;
  logic                       full_wake;
  logic [csw_pkg::HOLD_W-1:0] hold_limit;
  logic [csw_pkg::DATA_W-1:0] status_word;

  always_comb begin
    pin_s      = r_r.pin_sync[1];
    pin_fall   = r_r.pin_prev && !pin_s;
    activity   = rf_data_rx || serial_rx;
    full_wake  = r_r.opts[csw_pkg::OPT_FULL_WAKE_BIT];
    hold_limit = (csw_pkg::HOLD_W'(r_r.sleep_period) * csw_pkg::HOLD_MUL)
                 >> csw_pkg::HOLD_SHIFT;
    status_word = '0;
    status_word[csw_pkg::STAT_STATE_LSB +: 2]           = r_r.state;
    status_word[csw_pkg::STAT_IND_BIT]                  = (r_r.state == csw_pkg::ST_AWAKE);
    status_word[csw_pkg::STAT_HOST_BIT]                 = host_tx_allow;
    status_word[csw_pkg::STAT_PEND_BIT]                 = r_r.pend;
    status_word[csw_pkg::STAT_CYC_LSB +: csw_pkg::CYC_W] = r_r.cycle_cnt;
  end

  always_comb begin
    r_nxt = r_r;
    r_nxt.discard  = 1'b0;
    r_nxt.pin_sync = {r_r.pin_sync[0], sleep_request_pin};
    r_nxt.pin_prev = pin_s;

    // register writes
    if (wr) begin
      case (addr)
        csw_pkg::ADDR_MODE: begin
          case (wdata[csw_pkg::MODE_W-1:0])
            csw_pkg::MODE_NONE,
            csw_pkg::MODE_PIN,
            csw_pkg::MODE_CYCLIC,
            csw_pkg::MODE_CYCLIC_PIN: begin
              r_nxt.mode = csw_pkg::csw_mode_type'(wdata[csw_pkg::MODE_W-1:0]);
            end
            default: begin
              r_nxt.mode = r_r.mode;
            end
          endcase
        end
        csw_pkg::ADDR_OPTIONS: begin
          r_nxt.opts = wdata[csw_pkg::OPTS_W-1:0];
        end
        csw_pkg::ADDR_WAKE_TIME: begin
          r_nxt.wake_time = wdata[csw_pkg::WAKE_W-1:0];
        end
        csw_pkg::ADDR_SLEEP_PERIOD: begin
          r_nxt.sleep_period = wdata[csw_pkg::SLEEP_W-1:0];
        end
        csw_pkg::ADDR_CYCLES: begin
          r_nxt.cycles = wdata[csw_pkg::CYC_W-1:0];
        end
        csw_pkg::ADDR_HOST_DELAY: begin
          r_nxt.host_delay = wdata[csw_pkg::HOST_W-1:0];
        end
        default: begin
          r_nxt.opts = r_r.opts;
        end
      endcase
    end

    // register reads, data one cycle later
    r_nxt.rdata = '0;
    if (rd) begin
      case (addr)
        csw_pkg::ADDR_MODE:         r_nxt.rdata = csw_pkg::DATA_W'(r_r.mode);
        csw_pkg::ADDR_OPTIONS:      r_nxt.rdata = csw_pkg::DATA_W'(r_r.opts);
        csw_pkg::ADDR_WAKE_TIME:    r_nxt.rdata = csw_pkg::DATA_W'(r_r.wake_time);
        csw_pkg::ADDR_SLEEP_PERIOD: r_nxt.rdata = csw_pkg::DATA_W'(r_r.sleep_period);
        csw_pkg::ADDR_CYCLES:       r_nxt.rdata = csw_pkg::DATA_W'(r_r.cycles);
        csw_pkg::ADDR_HOST_DELAY:   r_nxt.rdata = csw_pkg::DATA_W'(r_r.host_delay);
        csw_pkg::ADDR_STATUS:       r_nxt.rdata = status_word;
        default:                    r_nxt.rdata = '0;
      endcase
    end

    // sleep sequencing
    case (r_r.mode)
      csw_pkg::MODE_NONE: begin
        r_nxt.state = csw_pkg::ST_AWAKE;
      end
      csw_pkg::MODE_PIN: begin
        r_nxt.state = pin_s ? csw_pkg::ST_SLEEP : csw_pkg::ST_AWAKE;
        r_nxt.wake_cnt = '0;
      end
      csw_pkg::MODE_CYCLIC,
      csw_pkg::MODE_CYCLIC_PIN: begin
        case (r_r.state)
          csw_pkg::ST_SLEEP: begin
            if (r_r.mode == csw_pkg::MODE_CYCLIC_PIN && pin_fall) begin
              r_nxt.state     = csw_pkg::ST_AWAKE;
              r_nxt.wake_cnt  = '0;
              r_nxt.sleep_cnt = '0;
              r_nxt.cycle_cnt = '0;
            end else if (tick_10ms) begin
              if (r_r.sleep_cnt + 1'b1 >= r_r.sleep_period) begin
                r_nxt.sleep_cnt = '0;
                if (r_r.cycle_cnt + 1'b1 >= r_r.cycles) begin
                  r_nxt.cycle_cnt = '0;
                  r_nxt.state     = csw_pkg::ST_AWAKE;
                  r_nxt.wake_cnt  = '0;
                end else begin
                  r_nxt.cycle_cnt = r_r.cycle_cnt + 1'b1;
                  r_nxt.state     = csw_pkg::ST_CHECK;
                  r_nxt.check_cnt = '0;
                end
              end else begin
                r_nxt.sleep_cnt = r_r.sleep_cnt + 1'b1;
              end
            end
          end
          csw_pkg::ST_CHECK: begin
            if (activity) begin
              r_nxt.state     = csw_pkg::ST_AWAKE;
              r_nxt.wake_cnt  = '0;
              r_nxt.cycle_cnt = '0;
            end else if (ms_tick) begin
              if (r_r.check_cnt == CHECK_LAST) begin
                r_nxt.state = csw_pkg::ST_SLEEP;
              end else begin
                r_nxt.check_cnt = r_r.check_cnt + 1'b1;
              end
            end
          end
          csw_pkg::ST_AWAKE: begin
            if (activity) begin
              r_nxt.wake_cnt = '0;
            end else if (r_r.mode == csw_pkg::MODE_CYCLIC_PIN && pin_s && !full_wake) begin
              r_nxt.state     = csw_pkg::ST_SLEEP;
              r_nxt.sleep_cnt = '0;
            end else if (ms_tick) begin
              if (r_r.wake_cnt + 1'b1 >= r_r.wake_time) begin
                r_nxt.state     = csw_pkg::ST_SLEEP;
                r_nxt.sleep_cnt = '0;
              end else begin
                r_nxt.wake_cnt = r_r.wake_cnt + 1'b1;
              end
            end
          end
          default: begin
            r_nxt.state     = csw_pkg::ST_SLEEP;
            r_nxt.sleep_cnt = '0;
          end
        endcase
      end
      default: begin
        r_nxt.state = csw_pkg::ST_AWAKE;
      end
    endcase

    // host wake delay
    if (serial_rx) begin
      r_nxt.host_cnt = '0;
    end else if (r_nxt.state == csw_pkg::ST_AWAKE && r_r.state != csw_pkg::ST_AWAKE) begin
      r_nxt.host_cnt = r_r.host_delay;
    end else if (ms_tick && r_r.host_cnt != '0) begin
      r_nxt.host_cnt = r_r.host_cnt - 1'b1;
    end

    // indirect message hold, store wins over take
    if (msg_store) begin
      r_nxt.pend     = 1'b1;
      r_nxt.hold_cnt = '0;
    end else if (msg_taken) begin
      r_nxt.pend = 1'b0;
    end else if (r_r.pend && tick_10ms) begin
      if (r_r.hold_cnt + 1'b1 >= hold_limit) begin
        r_nxt.pend    = 1'b0;
        r_nxt.discard = 1'b1;
      end else begin
        r_nxt.hold_cnt = r_r.hold_cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      r_r <= csw_pkg::REGS_RESET;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign rdata           = r_r.rdata;
  assign msg_discard     = r_r.discard;
  assign awake           = (r_r.state != csw_pkg::ST_SLEEP);
  assign awake_indicator = (r_r.state == csw_pkg::ST_AWAKE);
  assign host_tx_allow   = awake_indicator && (r_r.host_cnt == '0);

endmodule : csw_cyclic_sleep

// [logic/csw_pkg.sv]
package csw_pkg;

  // clock and tick timing
  localparam int unsigned CLK_PERIOD_PS  = 5000;
  localparam int unsigned MS_PS          = 1000000000;
  localparam int unsigned MS_CYCLES      = MS_PS / CLK_PERIOD_PS;
  localparam int unsigned SLEEP_UNIT_MS  = 10;
  localparam int unsigned CHECK_TIME_MS  = 5;

  // register bus
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  localparam logic [ADDR_W-1:0] ADDR_MODE         = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_OPTIONS      = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_WAKE_TIME    = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_SLEEP_PERIOD = 8'h0C;
  localparam logic [ADDR_W-1:0] ADDR_CYCLES       = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_HOST_DELAY   = 8'h14;
  localparam logic [ADDR_W-1:0] ADDR_STATUS       = 8'h18;

  // field widths
  localparam int unsigned MODE_W  = 3;
  localparam int unsigned OPTS_W  = 16;
  localparam int unsigned WAKE_W  = 22;
  localparam int unsigned SLEEP_W = 21;
  localparam int unsigned CYC_W   = 16;
  localparam int unsigned HOST_W  = 16;
  localparam int unsigned CHECK_W = 3;
  localparam int unsigned HOLD_W  = 24;

  // option bit: in cyclic pin mode, stay awake for the full wake time despite the pin
  localparam int unsigned OPT_FULL_WAKE_BIT = 8;

  // pending message hold: 2.5 sleep periods as 5/2
  localparam logic [HOLD_W-1:0] HOLD_MUL   = 24'h000005;
  localparam int unsigned       HOLD_SHIFT = 1;

  // status word layout
  localparam int unsigned STAT_STATE_LSB = 0;
  localparam int unsigned STAT_IND_BIT   = 2;
  localparam int unsigned STAT_HOST_BIT  = 3;
  localparam int unsigned STAT_PEND_BIT  = 4;
  localparam int unsigned STAT_CYC_LSB   = 16;

  // reset values
  localparam logic [OPTS_W-1:0]  OPTS_RESET   = 16'h0000;
  localparam logic [WAKE_W-1:0]  WAKE_RESET   = 22'h0007D0;
  localparam logic [SLEEP_W-1:0] SLEEP_RESET  = 21'h0000C8;
  localparam logic [CYC_W-1:0]   CYCLES_RESET = 16'h0001;
  localparam logic [HOST_W-1:0]  HOST_RESET   = 16'h0000;

  typedef enum logic [MODE_W-1:0] {
    MODE_NONE       = 3'h0,
    MODE_PIN        = 3'h1,
    MODE_CYCLIC     = 3'h4,
    MODE_CYCLIC_PIN = 3'h5
  } csw_mode_type;

  // gray along sleep -> check -> awake
  typedef enum logic [1:0] {
    ST_SLEEP = 2'h0,
    ST_CHECK = 2'h1,
    ST_AWAKE = 2'h3
  } csw_state_type;

  typedef struct packed {
    csw_mode_type        mode;
    logic [OPTS_W-1:0]   opts;
    logic [WAKE_W-1:0]   wake_time;
    logic [SLEEP_W-1:0]  sleep_period;
    logic [CYC_W-1:0]    cycles;
    logic [HOST_W-1:0]   host_delay;
    logic [1:0]          pin_sync;
    logic                pin_prev;
    csw_state_type       state;
    logic [WAKE_W-1:0]   wake_cnt;
    logic [SLEEP_W-1:0]  sleep_cnt;
    logic [CYC_W-1:0]    cycle_cnt;
    logic [CHECK_W-1:0]  check_cnt;
    logic [HOST_W-1:0]   host_cnt;
    logic                pend;
    logic [HOLD_W-1:0]   hold_cnt;
    logic                discard;
    logic [DATA_W-1:0]   rdata;
  } csw_regs_type;

  localparam csw_regs_type REGS_RESET = '{
    mode:         MODE_NONE,
    opts:         OPTS_RESET,
    wake_time:    WAKE_RESET,
    sleep_period: SLEEP_RESET,
    cycles:       CYCLES_RESET,
    host_delay:   HOST_RESET,
    pin_sync:     2'h3,
    pin_prev:     1'b1,
    state:        ST_AWAKE,
    default:      '0
  };

endpackage : csw_pkg

// [logic/csw_prescale.sv]
module csw_prescale #(
  parameter int unsigned DIV = 10
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // enable in, divided pulse out
  input  wire logic en,
  output logic      tick
);

  localparam int unsigned CW = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    if (en) begin
      cnt_nxt = (cnt_r == LAST) ? '0 : cnt_r + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign tick = en && (cnt_r == LAST);

endmodule : csw_prescale

// [verification/csw_cyclic_sleep_properties.sv]
module csw_cyclic_sleep_properties (
  // clock and reset
  input wire logic        clk,
  input wire logic        reset,
  // register port
  input wire logic [7:0]  addr,
  input wire logic [31:0] wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [31:0] rdata,
  // pins and status
  input wire logic        sleep_request_pin,
  input wire logic        rf_data_rx,
  input wire logic        serial_rx,
  input wire logic        msg_discard,
  input wire logic        awake,
  input wire logic        awake_indicator,
  input wire logic        host_tx_allow
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  logic [2:0] mode_r;

  // shadow of the accepted mode
  always_ff @(posedge clk) begin
    if (reset)
      mode_r <= 3'h0;
    else if (wr && addr == 8'h00 && wdata[2:0] inside {3'h0, 3'h1, 3'h4, 3'h5})
      mode_r <= wdata[2:0];
  end

  a_rdata_idle_zero: assert property (!$past(rd) |-> rdata == 32'h0)
    else $error("read data not zero outside answer cycle");
  a_none_stays_awake: assert property (mode_r == 3'h0 |-> ##2 awake_indicator)
    else $error("no sleep mode left awake state");
  a_pin_sleeps: assert property ((mode_r == 3'h1 && sleep_request_pin) [*5] |-> !awake)
    else $error("pin sleep request not obeyed");
  a_pin_wakes: assert property ((mode_r == 3'h1 && !sleep_request_pin) [*5] |-> awake_indicator)
    else $error("pin release did not wake");
  a_cyclic_sleep_min: assert property (mode_r == 3'h4 && $fell(awake) |-> !awake [*8])
    else $error("sleep period ended too early");
  a_pin_edge_wake: assert property (mode_r == 3'h5 && !awake && $fell(sleep_request_pin) |-> ##[1:6] awake_indicator)
    else $error("falling pin did not end sleep");
  a_check_bounded: assert property ($rose(awake) && !awake_indicator |-> ##[1:24] (!awake || awake_indicator))
    else $error("check window too long");
  a_check_data_wake: assert property (awake && !awake_indicator && rf_data_rx |-> ##[1:2] awake_indicator)
    else $error("data during check did not wake");
  a_host_needs_ind: assert property (host_tx_allow |-> awake_indicator)
    else $error("host output allowed while not awake");
  a_serial_frees_host: assert property (awake_indicator && serial_rx |=> host_tx_allow || !awake_indicator)
    else $error("serial input did not stop host delay");
  a_discard_pulse: assert property (msg_discard |=> !msg_discard)
    else $error("discard pulse longer than one cycle");
endmodule : csw_cyclic_sleep_properties

bind csw_cyclic_sleep csw_cyclic_sleep_properties u_props (
  .clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .sleep_request_pin(sleep_request_pin), .rf_data_rx(rf_data_rx), .serial_rx(serial_rx),
  .msg_discard(msg_discard), .awake(awake), .awake_indicator(awake_indicator),
  .host_tx_allow(host_tx_allow)
);

// [verification/csw_host_model.sv]
module csw_host_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       reset,
  // bench commands
  input  wire logic       want_sleep,
  input  wire logic       talk,
  input  wire logic [1:0] lag,
  // device status
  input  wire logic       awake_indicator,
  // pins to device
  output logic            sleep_request_pin,
  output logic            serial_rx
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [3:0] hist_r;

  // host only talks while the device is fully awake
  always @(posedge clk) begin
    if (reset) begin
      hist_r <= 4'h0;
      serial_rx <= 1'b0;
    end else begin
      hist_r <= {hist_r[2:0], want_sleep};
      serial_rx <= talk && awake_indicator;
    end
  end

  // slow or prompt host: pin follows the request after lag plus one cycles
  assign sleep_request_pin = hist_r[lag];
endmodule : csw_host_model

// [verification/cyclic_sleep_wake_control_bench.sv]
module cyclic_sleep_wake_control_bench;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk        = 1'b0;
  logic        reset      = 1'b1;
  logic [7:0]  addr       = 8'h00;
  logic [31:0] wdata      = 32'h0;
  logic        wr         = 1'b0;
  logic        rd         = 1'b0;
  logic        want_sleep = 1'b0;
  logic [1:0]  lag        = 2'h0;
  logic [3:0]  pls        = 4'h0;
  logic [31:0] rdata;
  logic        sleep_request_pin;
  logic        serial_rx;
  logic        msg_discard;
  logic        awake;
  logic        awake_indicator;
  logic        host_tx_allow;
  int          err_count  = 0;
  int          checked    = 0;
  int          model_m[8] = '{0, 0, 32'h7D0, 32'hC8, 1, 0, 32'hF, 0};
  int          modes[8]   = '{2, 3, 6, 7, 1, 4, 5, 0};

  always #2.5 clk = ~clk;

  csw_cyclic_sleep #(.MS_CYCLES(4)) dut (
    .clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .sleep_request_pin(sleep_request_pin), .rf_data_rx(pls[0]), .serial_rx(serial_rx),
    .msg_store(pls[1]), .msg_taken(pls[2]), .msg_discard(msg_discard), .awake(awake),
    .awake_indicator(awake_indicator), .host_tx_allow(host_tx_allow)
  );

  csw_host_model host (
    .clk(clk), .reset(reset), .want_sleep(want_sleep), .talk(pls[3]), .lag(lag),
    .awake_indicator(awake_indicator), .sleep_request_pin(sleep_request_pin),
    .serial_rx(serial_rx)
  );

  task automatic end_of_test();
    if (err_count == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_of_test

  task automatic tally(input bit ok, input string what);
    checked++;
    if (!ok) begin
      err_count++;
      $display("mismatch at %0t: %s", $time, what);
    end
  endtask : tally

  // model keeps accepted writes only
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    if (a < 8'h18 && (a != 8'h00 || d inside {0, 1, 4, 5}))
      model_m[a[4:2]] = d;
  endtask : wr_reg

  task automatic rd_chk(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    tally(rdata === 32'(model_m[a[4:2]]), "register read");
  endtask : rd_chk

  task automatic cmp_span(input int n, input int lo, input int hi);
    tally(n >= lo && n <= hi, "interval length");
  endtask : cmp_span

  task automatic cmp_bit(input logic got, input logic exp);
    tally(got === exp, "status level");
  endtask : cmp_bit

  task automatic pulse(input int w);
    @(posedge clk);
    pls <= 4'(1 << w);
    @(posedge clk);
    pls <= 4'h0;
  endtask : pulse

  function automatic logic pick(input int w);
    case (w)
      0: pick = awake;
      1: pick = awake_indicator;
      2: pick = msg_discard;
      default: pick = host_tx_allow;
    endcase
  endfunction : pick

  task automatic wait_on(input int w, input logic v, output int n);
    n = 0;
    #1;
    while (pick(w) !== v && n < 20000) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask : wait_on

  initial begin
    #200000;
    err_count++;
    end_of_test();
  end

  initial begin
    int n;
    int m;
    void'($urandom(32'h932B));
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    lag <= 2'($urandom_range(0, 3));
    for (int i = 0; i < 8; i++)
      rd_chk(8'(4 * i));
    for (int i = 0; i < 8; i++) begin
      wr_reg(8'h00, 32'(modes[i]));
      rd_chk(8'h00);
    end
    wr_reg(8'h04, 32'($urandom_range(0, 16'hFFFF)) | 32'h100);
    wr_reg(8'h1C, 32'h5);
    rd_chk(8'h04);
    rd_chk(8'h1C);
    wr_reg(8'h04, 32'h0);
    // pin sleep follows the host
    wr_reg(8'h00, 32'h1);
    want_sleep <= 1'b1;
    wait_on(0, 1'b0, n);
    cmp_span(n, 3, 9);
    want_sleep <= 1'b0;
    wait_on(1, 1'b1, n);
    cmp_span(n, 3, 9);
    // timed cycling, two periods per indication
    wr_reg(8'h0C, 32'h2);
    wr_reg(8'h10, 32'h2);
    wr_reg(8'h08, 32'h45);
    wr_reg(8'h14, 32'h20);
    wr_reg(8'h00, 32'h4);
    wait_on(0, 1'b0, n);
    wait_on(0, 1'b1, n);
    cmp_span(n, 40, 83);
    cmp_bit(awake_indicator, 1'b0);
    wait_on(0, 1'b0, n);
    cmp_span(n, 15, 22);
    wait_on(0, 1'b1, n);
    cmp_span(n, 40, 83);
    cmp_bit(awake_indicator, 1'b1);
    wait_on(3, 1'b1, n);
    cmp_span(n, 124, 130);
    wait_on(1, 1'b0, m);
    cmp_span(n + m, 268, 282);
    wait_on(0, 1'b0, n);
    wait_on(0, 1'b1, n);
    pulse(0);
    repeat (2) @(posedge clk);
    #1;
    cmp_bit(awake_indicator, 1'b1);
    pulse(3);
    repeat (2) @(posedge clk);
    #1;
    cmp_bit(host_tx_allow, 1'b1);
    // early wake on a falling pin
    wr_reg(8'h0C, 32'h64);
    want_sleep <= 1'b1;
    wr_reg(8'h00, 32'h5);
    wait_on(0, 1'b0, n);
    repeat (100) @(posedge clk);
    want_sleep <= 1'b0;
    wait_on(1, 1'b1, n);
    cmp_span(n, 3, 10);
    // pending message hold and delivery
    wr_reg(8'h0C, 32'h2);
    pulse(1);
    wait_on(2, 1'b1, n);
    cmp_span(n, 158, 203);
    pulse(1);
    pulse(2);
    repeat (250) begin
      @(posedge clk);
      #1;
      cmp_bit(msg_discard, 1'b0);
    end
    wr_reg(8'h00, 32'h0);
    repeat (4) @(posedge clk);
    #1;
    cmp_bit(awake_indicator, 1'b1);
    end_of_test();
  end
endmodule : cyclic_sleep_wake_control_bench
